/* rtl/pwm_output.v */
// pwm generator with shared base timer and axi4-lite register slave
// Notes on behaviour
// RULE1 - the output pin carries a pwm waveform whose duty has up to ten bits of resolution.
// RULE2 - software clears port direction bit 2 so the shared pin drives the waveform.
// RULE3 - writing zero to the whole control register forces the pwm latch low, not the port latch.
// RULE4 - the period is (period register + 1) times four oscillator periods times the prescale.
// RULE5 - when the timer equals the period register the next increment clears the timer.
// RULE6 - that same increment sets the output high unless the duty value is zero.
// RULE7 - that same increment copies the written duty into the internal duty latch.
// RULE8 - the postscaler does not shape the pwm frequency and only paces a slower update flag.
// RULE9 - the duty is the duty low register as eight msbs and control bits 5:4 as two lsbs.
// RULE10 - duty writes are taken at any time but only used after the next period match.
// RULE11 - in pwm mode the duty latch register is read-only and writes to it are ignored.
// RULE12 - the high time equals the duty value times one oscillator period times the prescale.
// RULE13 - the output falls when the timer with two fractional bits reaches the latched duty.
`include "pwm_defs.vh"
module pwm_output (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [4:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        port_pin_in,
    output reg         port_pin_out,
    output reg         port_pin_oe
);
    reg  [7:0] control_reg;
    reg  [7:0] period_reg;
    reg  [7:0] duty_low_reg;
    reg  [9:0] duty_latch_reg;
    reg  [6:0] timer_ctrl_reg;
    reg  [7:0] port_dir_reg;
    reg  [7:0] port_latch_reg;
    reg  [7:0] timer_reg;
    reg        pwm_latch_reg;
    reg  [3:0] post_cnt_reg;
    reg        update_flag_reg;
    reg        match_flag_reg;
    reg        aw_held_reg;
    reg        w_held_reg;
    reg  [4:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg  [3:0] w_strb_reg;
    reg        pin_meta_reg;
    reg        pin_sync_reg;
    wire       tick;
    wire [1:0] frac;
    wire       pwm_mode = (control_reg[`CTRL_MODE_HI:`CTRL_MODE_HI-1] == `MODE_PWM);
    wire       pwm_run  = pwm_mode && timer_ctrl_reg[`TCTRL_ON];
    wire       period_match = (timer_reg == period_reg);
    wire [9:0] duty_written = {duty_low_reg, control_reg[`CTRL_DUTY_LSB_HI:`CTRL_DUTY_LSB_LO]}; // RULE9
    wire       do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire       status_clear;
    // the registered latch alone would stretch every high phase by one clock cycle,
    // so the pin gate also ends the phase as soon as the count reaches the duty
    wire       pwm_level = pwm_latch_reg && ({timer_reg, frac} < duty_latch_reg); // RULE12 RULE13

    function is_addr;
        input [4:0] a;
        input [4:0] target;
        begin
            is_addr = (a[4:2] == target[4:2]);
        end
    endfunction

    pwm_prescaler u_prescaler (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .run          (pwm_run),
        .pre_sel      (timer_ctrl_reg[`TCTRL_PRE_HI:`TCTRL_PRE_LO]),
        .quarter_tick (tick),
        .frac         (frac)
    );

    // pin input passes two flops before being read back
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= port_pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // write channels are taken independently, in either order
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready  = !w_held_reg;
    assign s_axi_arready = !s_axi_rvalid;
    assign status_clear  = do_write && is_addr(aw_addr_reg, `ADDR_STATUS) && w_strb_reg[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            aw_addr_reg  <= 5'h00;
            w_data_reg   <= 32'h00000000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (s_axi_awvalid && !aw_held_reg) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_reg) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software registers; only byte lane 0 carries data
    always @(posedge aclk) begin
        if (!aresetn) begin
            control_reg    <= `RST_ZERO8;
            period_reg     <= `RST_PERIOD;
            duty_low_reg   <= `RST_ZERO8;
            timer_ctrl_reg <= 7'h00;
            port_dir_reg   <= `RST_PORT_DIR;
            port_latch_reg <= `RST_ZERO8;
        end else if (do_write && w_strb_reg[0]) begin
            case (aw_addr_reg[4:2])
                3'h0:    control_reg    <= w_data_reg[7:0];
                3'h1:    period_reg     <= w_data_reg[7:0];
                3'h2:    duty_low_reg   <= w_data_reg[7:0];
                3'h4:    timer_ctrl_reg <= w_data_reg[6:0];
                3'h6:    port_dir_reg   <= w_data_reg[7:0];
                3'h7:    port_latch_reg <= w_data_reg[7:0];
                default: port_latch_reg <= port_latch_reg;
            endcase
        end
    end

    // base timer, duty latch and output latch
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_reg       <= 8'h00;
            duty_latch_reg  <= 10'h000;
            pwm_latch_reg   <= 1'b0;
            post_cnt_reg    <= 4'h0;
            update_flag_reg <= 1'b0;
            match_flag_reg  <= 1'b0;
        end else begin
            if (!pwm_mode && do_write && w_strb_reg[0] && is_addr(aw_addr_reg, `ADDR_DUTY_LATCH)) begin
                duty_latch_reg <= {w_data_reg[7:0], 2'h0}; // RULE11
            end
            // clear first so that a match in the same cycle overrides it
            if (status_clear) begin
                match_flag_reg  <= match_flag_reg & ~w_data_reg[0];
                update_flag_reg <= update_flag_reg & ~w_data_reg[1];
            end
            if (pwm_run && tick) begin
                if (period_match) begin
                    timer_reg      <= 8'h00; // RULE5
                    duty_latch_reg <= duty_written; // RULE7 RULE10
                    pwm_latch_reg  <= (duty_written != 10'h000); // RULE6
                    match_flag_reg <= 1'b1;
                    // postscaler only paces the update flag, never the period
                    if (post_cnt_reg == timer_ctrl_reg[`TCTRL_POST_HI:`TCTRL_POST_LO]) begin
                        post_cnt_reg    <= 4'h0;
                        update_flag_reg <= 1'b1; // RULE8
                    end else begin
                        post_cnt_reg <= post_cnt_reg + 4'h1;
                    end
                end else begin
                    timer_reg <= timer_reg + 8'h01; // RULE4
                end
            end
            // fall on timer:frac reaching duty, checked every clock cycle except a period-match tick
            if (pwm_run && !(tick && period_match) && ({timer_reg, frac} >= duty_latch_reg)) begin
                pwm_latch_reg <= 1'b0; // RULE12 RULE13
            end
            if (do_write && is_addr(aw_addr_reg, `ADDR_CONTROL) && w_strb_reg[0] && w_data_reg[7:0] == 8'h00) begin
                pwm_latch_reg <= 1'b0; // RULE3
            end
        end
    end

    // pin mux: pwm latch overrides port latch when mode is pwm
    always @(posedge aclk) begin
        if (!aresetn) begin
            port_pin_out <= 1'b0;
            port_pin_oe  <= 1'b0;
        end else begin
            port_pin_out <= pwm_mode ? pwm_level : port_latch_reg[`PORT_PWM_BIT]; // RULE1
            port_pin_oe  <= !port_dir_reg[`PORT_PWM_BIT]; // RULE2
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr[4:2])
                3'h0:    s_axi_rdata <= {24'h000000, control_reg};
                3'h1:    s_axi_rdata <= {24'h000000, period_reg};
                3'h2:    s_axi_rdata <= {24'h000000, duty_low_reg};
                3'h3:    s_axi_rdata <= {22'h000000, duty_latch_reg};
                3'h4:    s_axi_rdata <= {17'h00000, timer_reg, timer_ctrl_reg};
                3'h5:    s_axi_rdata <= {28'h0000000, pwm_latch_reg, pin_sync_reg, update_flag_reg, match_flag_reg};
                3'h6:    s_axi_rdata <= {24'h000000, port_dir_reg};
                default: s_axi_rdata <= {24'h000000, port_latch_reg};
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // pwm_output

/* rtl/pwm_defs.vh */
// constants for the timer based pwm output block
`ifndef PWM_DEFS_VH
`define PWM_DEFS_VH
`define ADDR_CONTROL      5'h00
`define ADDR_PERIOD       5'h04
`define ADDR_DUTY_LOW     5'h08
`define ADDR_DUTY_LATCH   5'h0C
`define ADDR_TIMER_CTRL   5'h10
`define ADDR_STATUS       5'h14
`define ADDR_PORT_DIR     5'h18
`define ADDR_PORT_LATCH   5'h1C
`define CTRL_DUTY_LSB_HI  5
`define CTRL_DUTY_LSB_LO  4
`define CTRL_MODE_HI      3
`define CTRL_MODE_LO      0
`define MODE_PWM          2'h3
`define TCTRL_ON          2
`define TCTRL_PRE_HI      1
`define TCTRL_PRE_LO      0
`define TCTRL_POST_HI     6
`define TCTRL_POST_LO     3
`define PORT_PWM_BIT      2
`define RST_PERIOD        8'hFF
`define RST_PORT_DIR      8'hFF
`define RST_ZERO8         8'h00
`define OSC_PER_TICK      3'h4
`endif

/* rtl/pwm_prescaler.v */
// oscillator divider and prescaler producing one-cycle timer ticks
module pwm_prescaler (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       run,
    input  wire [1:0] pre_sel,
    output reg        quarter_tick,
    output reg  [1:0] frac
);
    reg [5:0] cnt_reg;
    reg [5:0] limit;
    // prescale 1, 4, 16 (code 2 and 3), times four oscillator periods per increment
    always @* begin
        case (pre_sel)
            2'h0:    limit = 6'h03;
            2'h1:    limit = 6'h0F;
            default: limit = 6'h3F;
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_reg      <= 6'h00;
            quarter_tick <= 1'b0;
            frac         <= 2'h0;
        end else begin
            quarter_tick <= (cnt_reg == limit);
            cnt_reg      <= (cnt_reg == limit) ? 6'h00 : cnt_reg + 6'h01;
            // two fractional bits: quarters of a timer increment
            case (pre_sel)
                2'h0:    frac <= cnt_reg[1:0];
                2'h1:    frac <= cnt_reg[3:2];
                default: frac <= cnt_reg[5:4];
            endcase
        end
    end
endmodule // pwm_prescaler

/* test/pwm_output_sva.sv */
// port assertions for the pwm block
module pwm_output_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        port_pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer withdrawn");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_done: assert property (p_b_done) else $error("write answer repeated");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer withdrawn");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_done: assert property (p_r_done) else $error("read answer repeated");
    property p_r_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_next: assert property (p_r_next) else $error("read answer late");
    property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("read taken while answering");
    property p_okay; s_axi_rvalid |-> s_axi_rresp == 2'h0; endproperty
    a_okay: assert property (p_okay) else $error("read response not okay");
    // shortest period is four oscillator periods, so rises never crowd
    property p_rise_gap; $rose(port_pin_out) |=> !$rose(port_pin_out) [*3]; endproperty
    a_rise_gap: assert property (p_rise_gap) else $error("pin rises too often");
    c_rise: cover property ($rose(port_pin_out));
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // pwm_output_sva
bind pwm_output pwm_output_sva u_sva (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .port_pin_out);

/* test/pwm_load.sv */
// external load on the shared pin
module pwm_load (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output wire logic pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // pulled down: a released pin reads low, never the last drive
    assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule // pwm_load

/* test/testbench.sv */
// register-level tests of the pwm block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         port_pin_out, port_pin_oe, port_pin_in;
    int          bad_count = 0, samples_checked = 0, hi, per;
    logic [31:0] rv;
    always #5 aclk = ~aclk;
    pwm_output u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .port_pin_in, .port_pin_out, .port_pin_oe);
    pwm_load u_load (.pin_out(port_pin_out), .pin_oe(port_pin_oe), .pin_level(port_pin_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 99);
        s_axi_bready <= 1'b0;
        if (n >= 99) chk(0, 1);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 99);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (n >= 99) chk(0, 1);
    endtask
    // counts one whole high phase and the low phase after it
    task automatic measure(output int h, output int p);
        int n = 0;
        h = 0;
        while (port_pin_in === 1'b1 && n < 999) begin
            @(posedge aclk);
            n++;
        end
        while (port_pin_in !== 1'b1 && n < 999) begin
            @(posedge aclk);
            n++;
        end
        while (port_pin_in === 1'b1 && n < 999) begin
            @(posedge aclk);
            n++;
            h++;
        end
        p = h;
        while (port_pin_in !== 1'b1 && n < 999) begin
            @(posedge aclk);
            n++;
            p++;
        end
        if (n >= 999) chk(0, 1);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200us;
        bad_count++;
        results();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(5'h04, rv);
        chk(rv & 32'hFF, 32'hFF);
        rd(5'h18, rv);
        chk(rv & 32'hFF, 32'hFF);
        wr(5'h18, 32'hFB);
        wr(5'h04, 32'h03);
        wr(5'h08, 32'h02);
        wr(5'h00, 32'h1C);
        // second pass also sets the largest postscale, which must not move the period
        for (int p = 0; p < 2; p++) begin
            wr(5'h10, 32'h04 | p * 32'h79);
            measure(hi, per);
            measure(hi, per);
            chk(hi, 9 << (2 * p));
            chk(per, 16 << (2 * p));
        end
        rd(5'h0C, rv);
        chk(rv & 32'h3FF, 32'h9);
        wr(5'h0C, 32'h55);
        rd(5'h0C, rv);
        chk(rv & 32'h3FF, 32'h9);
        // resync just after a match, then flags, clear and a mid-period duty write
        measure(hi, per);
        rd(5'h14, rv);
        chk(rv & 32'h3, 32'h3);
        wr(5'h14, 32'h3);
        wr(5'h08, 32'h01);
        rd(5'h0C, rv);
        chk(rv & 32'h3FF, 32'h9);
        rd(5'h14, rv);
        chk(rv & 32'h3, 32'h0);
        measure(hi, per);
        chk(hi, 20);
        chk(per, 64);
        rd(5'h14, rv);
        chk(rv & 32'h3, 32'h1);
        rd(5'h0C, rv);
        chk(rv & 32'h3FF, 32'h5);
        wr(5'h1C, 32'h04);
        wr(5'h00, 32'h00);
        repeat (4) @(posedge aclk);
        chk(port_pin_out, 1);
        rd(5'h1C, rv);
        chk(rv & 32'hFF, 32'h04);
        rd(5'h14, rv);
        chk(rv & 32'hC, 32'h4);
        wr(5'h08, 32'h00);
        wr(5'h00, 32'h0C);
        repeat (130) @(posedge aclk);
        hi = 0;
        repeat (130) begin
            @(posedge aclk);
            hi += (port_pin_in === 1'b1);
        end
        chk(hi, 0);
        results();
    end
endmodule // testbench
